/* File: zrpo_pkg.sv */
package zrpo_pkg;
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned AXIS_N        = 2;
   // Fixed high time above 100 kHz on the two-axis variant, interpolation bit clear
   localparam int unsigned HIGH_FIX_NS   = 2500;
   localparam int unsigned HIGH_FIX_CYC  = HIGH_FIX_NS / 4;
   localparam int unsigned FREQ_SPLIT_HZ = 100_000;
   localparam int unsigned FREQ_MAX_HZ   = 200_000;
   localparam int unsigned FREQ_MIN_HZ   = 1;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_ZSPD   = 8'h08;
   localparam logic [7:0] OFS_CSPD   = 8'h0C;
   localparam logic [7:0] OFS_ZCNT   = 8'h10;
   localparam logic [7:0] OFS_CFG    = 8'h14;
   localparam logic [7:0] OFS_STAT   = 8'h18;
   localparam logic [7:0] OFS_PV0    = 8'h1C;
   localparam logic [7:0] OFS_PV1    = 8'h20;
   localparam logic [7:0] OFS_FREQ0  = 8'h24;
   localparam logic [7:0] OFS_FREQ1  = 8'h28;
   // Field positions in the command words
   localparam int unsigned BIT_ZRQ   = 4;
   localparam int unsigned BIT_SUBT  = 0;
   localparam int unsigned BIT_INSTR = 1;
   localparam int unsigned BIT_DIR   = 2;
   localparam int unsigned BIT_INTP  = 3;
   // Reset values
   localparam logic [17:0] ZSPD_RST  = 18'h03E80;
   localparam logic [17:0] CSPD_RST  = 18'h00064;
   localparam logic [15:0] ZCNT_RST  = 16'h0001;
   typedef enum logic [4:0] {
      ZRPO_IDLE  = 5'b00001,
      ZRPO_FAST  = 5'b00010,
      ZRPO_CREEP = 5'b00100,
      ZRPO_DRIVE = 5'b01000,
      ZRPO_DONE  = 5'b10000
   } zrpo_state_e;
endpackage : zrpo_pkg

/* File: zrpo_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Waveform chosen from frequency and the per-axis interpolation bit
// - Interpolated two-axis waveform, 1 Hz-100 kHz
// - Single-axis pulses 50/50 up to 200 kHz
// - Two-axis above 100 kHz, interpolation bit clear: fixed 2.5 us high
// - Two-axis up to 100 kHz: 50/50 duty
// - Present value follows emitted forward/reverse pulses
// - Present value cleared at power-up
// - Zero return at set direction and speed
// - Near-point switch drops speed to creep
// - Count zero pulses, stop, flag complete
// - Request pin: manual always, auto at end
// - Instruction ignored manual, runs in automatic
// - Subtask relay starts return only in automatic
// - Host bit 4 accepted like request pin
// - Per-axis completion flag on finish
// - New command clears flag until finish
// - Completion survives manual to automatic switch
// - Instruction relays watched constantly in automatic
// - Zero pulse read only running, after near-point
// - Near-point read before and during return
// - X00-X07 read only during interrupt instructions
// - Parameter-assigned inputs watched always in automatic
module zrpo_top
   import zrpo_pkg::*;
#(
   parameter int unsigned TWO_AXIS = 1
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        manual_mode_input,
   input  wire logic        stop_input,
   input  wire logic        end_step_idle,
   input  wire logic [1:0]  interrupt_instr_active,
   input  wire logic [1:0]  zero_return_request,
   input  wire logic [1:0]  near_point_input,
   input  wire logic [1:0]  zero_point_pulse_input,
   input  wire logic [1:0]  servo_ready_input,
   input  wire logic [1:0]  servo_positioning_done_input,
   input  wire logic [1:0]  forward_limit_switch,
   input  wire logic [1:0]  reverse_limit_switch,
   input  wire logic [7:0]  fast_inputs,
   input  wire logic [7:0]  param_inputs,
   output logic [1:0]       forward_pulse,
   output logic [1:0]       reverse_pulse,
   output logic [1:0]       zero_return_complete,
   output logic [1:0]       axis_running,
   output logic [7:0]       fast_inputs_latched,
   output logic [7:0]       param_inputs_seen
);
   localparam int unsigned NIN = 11;
   typedef struct packed {
      logic [NIN-1:0][1:0] sy1;
      logic [NIN-1:0][1:0] sy2;
      logic [7:0]          fx1;
      logic [7:0]          fx2;
      logic [7:0]          px1;
      logic [7:0]          px2;
      logic                aw_h;
      logic [7:0]          aw_a;
      logic                w_h;
      logic [31:0]         w_d;
      logic                w_s;
      logic                bv;
      logic                rv;
      logic [31:0]         rd;
      logic [1:0][7:0]     ctrl;
      logic [17:0]         zspd;
      logic [17:0]         cspd;
      logic [15:0]         zcnt;
      logic [1:0]          dir;
      logic [1:0]          intp;
      logic [1:0][17:0]    freq;
      logic [1:0]          done;
      logic [1:0]          done_ok;
      logic [1:0][4:0]     st;
      logic [1:0][31:0]    pv;
      logic [1:0][15:0]    pcnt;
      logic [1:0]          pg_prev;
      logic [1:0]          np_seen;
      logic [1:0][31:0]    acc;
      logic [1:0][31:0]    hcnt;
      logic [1:0]          phase;
      logic [1:0]          jog_forward_input;
      logic [1:0]          fp;
      logic [1:0]          rp;
      logic [7:0]          fxl;
      logic [7:0]          pxl;
   } zrpo_s;
   zrpo_s q, d;

   // Synchronised views: index 0 mode,1 stop,2 end,3 intr,4 zreq,5 np,
   // 6 pg,7 rdy,8 pdone,9 fwd limit,10 rev limit
   // Limits are merged after the flops so no gate sees a raw pin
   logic [NIN-1:0][1:0] raw;
   always_comb
   begin
      raw[0] = {1'b0, manual_mode_input};
      raw[1] = {1'b0, stop_input};
      raw[2] = {1'b0, end_step_idle};
      raw[3] = interrupt_instr_active;
      raw[4] = zero_return_request;
      raw[5] = near_point_input;
      raw[6] = zero_point_pulse_input;
      raw[7] = servo_ready_input;
      raw[8] = servo_positioning_done_input;
      raw[9]  = forward_limit_switch;
      raw[10] = reverse_limit_switch;
   end

   logic        manual;
   logic        aw_go;
   logic        ar_go;
   logic [31:0] rmux;

   always_comb
   begin
      manual = q.sy2[0][0];
      aw_go  = q.aw_h && q.w_h && !q.bv;
      ar_go  = s_axi_arvalid && !q.rv;
      if (s_axi_araddr == OFS_CTRL0)
         rmux = {24'h000000, q.ctrl[0]};
      else if (s_axi_araddr == OFS_CTRL1)
         rmux = {24'h000000, q.ctrl[1]};
      else if (s_axi_araddr == OFS_ZSPD)
         rmux = {14'h0000, q.zspd};
      else if (s_axi_araddr == OFS_CSPD)
         rmux = {14'h0000, q.cspd};
      else if (s_axi_araddr == OFS_ZCNT)
         rmux = {16'h0000, q.zcnt};
      else if (s_axi_araddr == OFS_CFG)
         rmux = {28'h0000000, q.intp, q.dir};
      else if (s_axi_araddr == OFS_STAT)
         rmux = {20'h00000, q.st[1], q.st[0], q.done};
      else if (s_axi_araddr == OFS_PV0)
         rmux = q.pv[0];
      else if (s_axi_araddr == OFS_PV1)
         rmux = q.pv[1];
      else if (s_axi_araddr == OFS_FREQ0)
         rmux = {14'h0000, q.freq[0]};
      else if (s_axi_araddr == OFS_FREQ1)
         rmux = {14'h0000, q.freq[1]};
      else
         rmux = 32'h00000000;
   end

   always_comb
   begin
      logic [1:0]  start;
      logic        run;
      logic        idle_ok;
      logic [31:0] half;
      logic [31:0] period;
      logic [31:0] hi;
      logic        pulse_now;
      logic        np;
      logic        pg;
      logic        wr;
      logic [7:0]  wa;
      logic        lim;
      start     = 2'b00;
      run       = 1'b0;
      idle_ok   = 1'b0;
      half      = 32'h00000000;
      period    = 32'h00000000;
      hi        = 32'h00000000;
      pulse_now = 1'b0;
      np        = 1'b0;
      pg        = 1'b0;
      wr        = 1'b0;
      wa        = 8'h00;
      lim       = 1'b0;
      d         = q;
      d.sy1     = raw;
      d.sy2     = q.sy1;
      d.fx1     = fast_inputs;
      d.fx2     = q.fx1;
      d.px1     = param_inputs;
      d.px2     = q.px1;
      // Bus slave: address and data may arrive in either order
      if (s_axi_awvalid && !q.aw_h)
      begin
         d.aw_h = 1'b1;
         d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_h)
      begin
         d.w_h = 1'b1;
         d.w_d = s_axi_wdata;
         d.w_s = s_axi_wstrb[0];
      end
      if (aw_go)
      begin
         wr     = q.w_s;
         wa     = q.aw_a;
         d.aw_h = 1'b0;
         d.w_h  = 1'b0;
         d.bv   = 1'b1;
      end
      if (q.bv && s_axi_bready)
         d.bv = 1'b0;
      if (ar_go)
      begin
         d.rv = 1'b1;
         d.rd = rmux;
      end
      else if (q.rv && s_axi_rready)
         d.rv = 1'b0;
      // Command words self-clear, so each write is one start event
      d.ctrl[0] = 8'h00;
      d.ctrl[1] = 8'h00;
      if (wr)
      begin
         if (wa == OFS_CTRL0)
            d.ctrl[0] = q.w_d[7:0];
         else if (wa == OFS_CTRL1)
            d.ctrl[1] = q.w_d[7:0];
         else if (wa == OFS_ZSPD)
            d.zspd = q.w_d[17:0];
         else if (wa == OFS_CSPD)
            d.cspd = q.w_d[17:0];
         else if (wa == OFS_ZCNT)
            d.zcnt = q.w_d[15:0];
         else if (wa == OFS_CFG)
         begin
            d.dir  = q.w_d[1:0];
            d.intp = q.w_d[3:2];
         end
      end
      // Fast inputs latched only during interrupt instructions
      if (!manual && q.sy2[3][0] && (q.st[0] != ZRPO_IDLE))
         d.fxl = q.fx2;
      if (!manual)
         d.pxl = q.px2;
      idle_ok = manual || q.sy2[2][0];
      for (int a = 0; a < AXIS_N; a++)
      begin
         np = q.sy2[5][a];
         pg = q.sy2[6][a];
         lim = q.sy2[9][a] || q.sy2[10][a];
         start[a] = (q.sy2[4][a] && idle_ok)
            || (q.ctrl[a][BIT_ZRQ] && idle_ok)
            || (!manual && q.ctrl[a][BIT_SUBT])
            || (!manual && q.ctrl[a][BIT_INSTR]);
         if (a == 1 && TWO_AXIS == 0)
            start[a] = 1'b0;
         run = (q.st[a] == ZRPO_FAST) || (q.st[a] == ZRPO_CREEP);
         d.pg_prev[a] = pg;
         case (q.st[a])
            ZRPO_IDLE:
            begin
               d.freq[a] = 18'h00000;
               if (start[a] && q.sy2[7][a] && !lim)
               begin
                  d.done[a]    = 1'b0;
                  d.done_ok[a] = 1'b0;
                  d.jog_forward_input[a]     = !q.dir[a];
                  d.np_seen[a] = np;
                  d.pcnt[a]    = 16'h0000;
                  d.st[a]      = np ? ZRPO_CREEP : ZRPO_FAST;
               end
            end
            ZRPO_FAST:
            begin
               d.freq[a] = q.zspd;
               if (np)
               begin
                  d.np_seen[a] = 1'b1;
                  d.st[a]      = ZRPO_CREEP;
               end
            end
            ZRPO_CREEP:
            begin
               d.freq[a] = q.cspd;
               if (q.np_seen[a] && pg && !q.pg_prev[a])
               begin
                  d.pcnt[a] = q.pcnt[a] + 16'h0001;
                  if (q.pcnt[a] + 16'h0001 >= q.zcnt)
                     d.st[a] = ZRPO_DRIVE;
               end
            end
            ZRPO_DRIVE:
            begin
               d.freq[a] = 18'h00000;
               // Done is stale until the last high time has ended
               if (!q.phase[a])
               begin
                  d.done_ok[a] = q.sy2[8][a];
                  if (q.sy2[8][a])
                     d.st[a] = ZRPO_DONE;
               end
            end
            default:
            begin
               d.done[a] = 1'b1;
               d.st[a]   = ZRPO_IDLE;
            end
         endcase
         if (run && (q.sy2[1][0] || !q.sy2[7][a] || lim))
         begin
            d.st[a]   = ZRPO_IDLE;
            d.freq[a] = 18'h00000;
         end
         // Phase accumulator: waveform depends on frequency and the interpolation bit
         period = (q.freq[a] == 18'h00000) ? 32'h00000000
                  : 32'(CLK_HZ / q.freq[a]);
         half   = period >> 1;
         if (TWO_AXIS != 0 && !q.intp[a] && q.freq[a] > FREQ_SPLIT_HZ)
            hi = HIGH_FIX_CYC;
         else
            hi = half;
         pulse_now = 1'b0;
         if (!run || period == 32'h00000000)
         begin
            d.acc[a]   = 32'h00000000;
            d.phase[a] = 1'b0;
            // A cut train still ends its last high time at full width
            if (q.phase[a] && q.acc[a] < q.hcnt[a])
            begin
               d.acc[a]   = q.acc[a] + 32'h00000001;
               d.phase[a] = 1'b1;
            end
         end
         else if (q.acc[a] + 32'h00000001 >= period)
            d.acc[a] = 32'h00000000;
         else
         begin
            d.acc[a] = q.acc[a] + 32'h00000001;
            if (q.acc[a] == 32'h00000000)
               pulse_now = 1'b1;
         end
         if (run && period != 32'h00000000)
         begin
            d.phase[a] = q.acc[a] < hi;
            d.hcnt[a]  = hi;
         end
         d.fp[a] = d.phase[a] && q.jog_forward_input[a];
         d.rp[a] = d.phase[a] && !q.jog_forward_input[a];
         if (pulse_now)
            d.pv[a] = q.jog_forward_input[a] ? q.pv[a] + 32'h00000001
                               : q.pv[a] - 32'h00000001;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q      <= '0; // Present value cleared at power-up
         q.st   <= {ZRPO_IDLE, ZRPO_IDLE};
         q.zspd <= ZSPD_RST;
         q.cspd <= CSPD_RST;
         q.zcnt <= ZCNT_RST;
      end
      else
         q <= d;
   end

   assign s_axi_awready        = !q.aw_h;
   assign s_axi_wready         = !q.w_h;
   assign s_axi_bvalid         = q.bv;
   assign s_axi_bresp          = 2'b00;
   assign s_axi_arready        = !q.rv;
   assign s_axi_rvalid         = q.rv;
   assign s_axi_rdata          = q.rd;
   assign s_axi_rresp          = 2'b00;
   assign forward_pulse        = q.fp;
   assign reverse_pulse        = q.rp;
   assign zero_return_complete = q.done;
   assign axis_running         = {q.st[1] inside {ZRPO_FAST, ZRPO_CREEP},
                                  q.st[0] inside {ZRPO_FAST, ZRPO_CREEP}};
   assign fast_inputs_latched  = q.fxl;
   assign param_inputs_seen    = q.pxl;
endmodule : zrpo_top

/* File: zrpo_monitor.sv */
`timescale 1ns/10ps
module zrpo_monitor
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [1:0]  forward_pulse,
   input wire logic [1:0]  reverse_pulse,
   input wire logic [1:0]  axis_running,
   input wire logic [1:0]  zero_return_complete
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   dir_excl_a: assert property (
      !(forward_pulse & reverse_pulse)) else $error("both directions");
   pulse_run_a: assert property (
      $rose(forward_pulse[0]) |-> axis_running[0]) else $error("stray pulse");
   // Shortest legal high time is 625 cycles, so 8 is a safe floor
   hi_min0_a: assert property (
      $rose(forward_pulse[0]) |-> forward_pulse[0] [*8]) else $error("short");
   hi_min1_a: assert property (
      $rose(reverse_pulse[1]) |-> reverse_pulse[1] [*8]) else $error("short");
   clear_new_a: assert property (
      $rose(axis_running[0]) |-> ##[0:3] !zero_return_complete[0])
      else $error("flag kept");
   hold_done_a: assert property (
      $fell(zero_return_complete[1]) |-> ##[0:4] axis_running[1])
      else $error("flag lost");
   done_stop_a: assert property (
      $rose(zero_return_complete[0]) |-> !forward_pulse[0] && !reverse_pulse[0])
      else $error("still moving");
   b_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
   r_lat_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'b00)
      else $error("r late");
   b_okay_a: assert property (
      s_axi_bvalid |-> s_axi_bresp == 2'b00) else $error("bresp");
endmodule : zrpo_monitor

/* File: zrpo_drive_model.sv */
`timescale 1ns/10ps
module zrpo_drive_model
#(
   parameter int unsigned NEAR_AT   = 3,
   parameter int unsigned IDLE_DONE = 2000
)(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] forward_pulse,
   input  wire logic [1:0] reverse_pulse,
   input  wire logic [1:0] axis_running,
   output logic [1:0]      near_point_input,
   output logic [1:0]      zero_point_pulse_input,
   output logic [1:0]      servo_ready_input,
   output logic [1:0]      servo_positioning_done_input,
   output logic [1:0]      forward_limit_switch,
   output logic [1:0]      reverse_limit_switch
);
   logic [1:0]  pulse;
   logic [1:0]  pulse_q;
   int unsigned steps [2];
   int unsigned idle [2];
   assign pulse = forward_pulse | reverse_pulse;
   // Encoder marks every step, also before the switch, so early counts show
   assign zero_point_pulse_input = pulse;
   assign servo_ready_input      = 2'b11;
   assign forward_limit_switch   = 2'b00;
   assign reverse_limit_switch   = 2'b00;
   always_ff @(posedge aclk)
   begin
      pulse_q <= pulse;
      for (int i = 0; i < 2; i++)
      begin
         if (!aresetn || !axis_running[i])
            steps[i] <= 0;
         else if (pulse[i] && !pulse_q[i])
            steps[i] <= steps[i] + 1;
         if (!aresetn || pulse[i])
            idle[i] <= 0;
         else if (idle[i] < IDLE_DONE)
            idle[i] <= idle[i] + 1;
         near_point_input[i] <= axis_running[i] && steps[i] >= NEAR_AT;
         // Settled only once the train has been quiet longer than a low half
         servo_positioning_done_input[i] <= idle[i] >= IDLE_DONE;
      end
   end
endmodule : zrpo_drive_model

/* File: zrpo_tb.sv */
`timescale 1ns/10ps
module zrpo_tb;
   import zrpo_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, n;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, near, zpulse, sready, sdone;
   logic        manual_mode_input = 1'b1, end_step_idle = 1'b0;
   logic [1:0]  zero_return_request = 2'b00, flim, rlim, fp_q, rp_q;
   logic [1:0]  forward_pulse, reverse_pulse, zero_return_complete;
   logic [1:0]  axis_running, interrupt_instr_active = 2'b00;
   logic [7:0]  param_inputs = 8'h00, param_inputs_seen;
   logic [7:0]  fast_inputs = 8'h00, fast_inputs_latched;
   logic [31:0] fcnt [2] = '{32'h0, 32'h0};
   logic [31:0] rcnt [2] = '{32'h0, 32'h0};
   int          num_errors = 0, checks = 0, cycles = 0;
   zrpo_top i_zrpo_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .manual_mode_input(manual_mode_input),
      .stop_input(1'b0), .end_step_idle(end_step_idle),
      .interrupt_instr_active(interrupt_instr_active),
      .zero_return_request(zero_return_request),
      .near_point_input(near), .zero_point_pulse_input(zpulse),
      .servo_ready_input(sready), .servo_positioning_done_input(sdone),
      .forward_limit_switch(flim), .reverse_limit_switch(rlim),
      .fast_inputs(fast_inputs), .param_inputs(param_inputs),
      .forward_pulse(forward_pulse), .reverse_pulse(reverse_pulse),
      .zero_return_complete(zero_return_complete), .axis_running(axis_running),
      .fast_inputs_latched(fast_inputs_latched),
      .param_inputs_seen(param_inputs_seen));
   zrpo_drive_model i_zrpo_drive_model (.aclk(aclk), .aresetn(aresetn),
      .forward_pulse(forward_pulse), .reverse_pulse(reverse_pulse),
      .axis_running(axis_running), .near_point_input(near),
      .zero_point_pulse_input(zpulse), .servo_ready_input(sready),
      .servo_positioning_done_input(sdone), .forward_limit_switch(flim),
      .reverse_limit_switch(rlim));
   always #2 aclk = ~aclk;
   always @(posedge aclk)
   begin
      fp_q <= forward_pulse;
      rp_q <= reverse_pulse;
      for (int i = 0; i < 2; i++)
      begin
         if (forward_pulse[i] && !fp_q[i]) fcnt[i] <= fcnt[i] + 1;
         if (reverse_pulse[i] && !rp_q[i]) rcnt[i] <= rcnt[i] + 1;
      end
      cycles++;
      // Four full returns fit well inside this ceiling
      if (cycles == 90000)
      begin
         num_errors++;
         finish_test();
      end
   end
   task finish_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task idle(input int c);
      repeat (c) @(posedge aclk);
   endtask : idle
   task wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   function automatic logic pl(input int i, input bit rev);
      return rev ? reverse_pulse[i] : forward_pulse[i];
   endfunction : pl
   // Skips a pulse already under way, then counts one whole high time
   task hi_width(input int i, input bit rev, output logic [31:0] w);
      do @(posedge aclk); while (pl(i, rev) !== 1'b0);
      do @(posedge aclk); while (pl(i, rev) !== 1'b1);
      w = 0;
      while (pl(i, rev) === 1'b1)
      begin
         @(posedge aclk);
         w++;
      end
   endtask : hi_width
   task wait_zrc(input int i, input logic lvl);
      do @(posedge aclk); while (zero_return_complete[i] !== lvl);
   endtask : wait_zrc
   initial
   begin
      idle(8);
      aresetn <= 1'b1;
      rd(OFS_PV0, d); chk(d, 32'h0);
      rd(OFS_STAT, d); chk(d & 32'h3, 32'h0);
      wr(8'h3C, 32'hFFFFFFFF); rd(8'h3C, d); chk(d, 32'h0);
      wr(OFS_ZSPD, 32'h000186A0);
      wr(OFS_CSPD, 32'h000186A0);
      wr(OFS_ZCNT, 32'h00000002);
      wr(OFS_CFG, 32'h00000002);
      for (int k = 1; k < 3; k++)
      begin
         wr(OFS_CTRL0, k); idle(20); chk(axis_running, 2'b00);
      end
      manual_mode_input <= 1'b0;
      wr(OFS_CTRL0, 32'h10);
      zero_return_request <= 2'b01;
      idle(20); chk(axis_running, 2'b00);
      zero_return_request <= 2'b00;
      manual_mode_input <= 1'b1;
      idle(4);
      wr(OFS_CTRL0, 32'h10);
      hi_width(0, 0, n); chk(n, CLK_HZ / 200_000);
      wait_zrc(0, 1'b1);
      chk(rcnt[0], 32'h0);
      rd(OFS_PV0, d); chk(d, fcnt[0]);
      chk(32'(fcnt[0] >= 32'h5), 32'h1);
      rd(OFS_STAT, d); chk(d & 32'h3, 32'h1);
      manual_mode_input <= 1'b0;
      param_inputs <= 8'h5A;
      idle(4); chk(zero_return_complete, 2'b01);
      chk(param_inputs_seen, 8'h5A);
      wr(OFS_ZSPD, 32'h000249F0);
      wr(OFS_CTRL1, 32'h1);
      hi_width(1, 1, n); chk(n, HIGH_FIX_CYC);
      wait_zrc(1, 1'b1);
      chk(fcnt[1], 32'h0);
      rd(OFS_PV1, d); chk(d, 32'h0 - rcnt[1]);
      end_step_idle <= 1'b1;
      zero_return_request <= 2'b10;
      wait_zrc(1, 1'b0);
      zero_return_request <= 2'b00;
      chk(axis_running, 2'b10);
      wait_zrc(1, 1'b1);
      chk(zero_return_complete, 2'b11);
      interrupt_instr_active <= 2'b01;
      fast_inputs <= 8'hC3;
      idle(4);
      chk(fast_inputs_latched, 8'h00);
      wr(OFS_CFG, 32'h00000006);
      wr(OFS_CTRL0, 32'h2);
      wait_zrc(0, 1'b0);
      hi_width(0, 0, n);
      chk(n, CLK_HZ / 150_000 / 2);
      chk(fast_inputs_latched, 8'hC3);
      wait_zrc(0, 1'b1); chk(zero_return_complete, 2'b11);
      finish_test();
   end
endmodule : zrpo_tb
bind zrpo_top zrpo_monitor i_zrpo_monitor (.aclk(aclk), .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .forward_pulse(forward_pulse),
   .reverse_pulse(reverse_pulse), .axis_running(axis_running),
   .zero_return_complete(zero_return_complete));
